// ---- logic/cie_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cie_defines.svh"
module cie_seq #(
    parameter int N     = 8,
    parameter int IDX_W = 3
) (
    input  wire logic             clk_sys,        // core bus clock
    input  wire logic             sys_rst,        // sync reset, high
    input  wire logic             clk_en,         // freeze when low
    input  wire logic [N-1:0]     src_event,      // peripheral event pulses
    input  wire logic [N-1:0]     src_ien,        // local interrupt enables
    input  wire logic [N-1:0]     src_flag_clr,   // flag clear pulses
    output logic      [N-1:0]     src_flag,       // status flags
    input  wire logic             instr_boundary, // current instruction done
    input  wire logic             swi_exec,       // software trap at boundary
    input  wire logic             rti_exec,       // return at boundary
    input  wire logic             dbg_swi,        // debug trap pulse
    input  wire logic             ccr_i_set,      // software sets mask
    input  wire logic             ccr_i_clr,      // software clears mask
    input  wire logic [15:0]      pc_next,        // next main-program address
    input  wire logic [15:0]      sp_in,          // stack pointer from core
    input  wire logic [7:0]       acc_in,         // accumulator
    input  wire logic [7:0]       idx_lo_in,      // low index byte
    input  wire logic [7:0]       ccr_in,         // condition codes
    output logic                  mem_rd,         // read strobe
    output logic                  mem_wr,         // write strobe
    output logic      [15:0]      mem_addr,       // access address
    output logic      [7:0]       mem_wdata,      // write data
    input  wire logic [7:0]       mem_rdata,      // data of last cycle's read
    output logic                  busy,           // sequence running
    output logic                  i_mask,         // global mask bit
    output logic      [15:0]      stack_pointer,  // working stack pointer
    output logic      [15:0]      program_counter,// vector or pulled address
    output logic      [7:0]       ccr_out,        // pulled condition codes
    output logic      [7:0]       acc_out,        // pulled accumulator
    output logic      [7:0]       idx_lo_out,     // pulled low index
    output logic      [7:0]       q_byte,         // queue fill byte
    output logic                  q_valid,        // queue byte strobe
    output logic                  entry_done,     // entry finished pulse
    output logic                  rti_done        // return finished pulse
);
    import cie_pkg::*;

    // *****************************************
    // request qualification
    // *****************************************
    logic             hw_any;
    logic [IDX_W-1:0] hw_idx;
    logic [N-1:0]     hw_req;

    cie_flags #(.N(N)) u_flags (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .evt     (src_event),
        .clr     (src_flag_clr),
        .flag    (src_flag)
    );

    // local enable gates each flag; global mask applied at boundary
    assign hw_req = src_flag & src_ien;

    cie_prio #(.N(N), .IDX_W(IDX_W)) u_prio (
        .req (hw_req),
        .any (hw_any),
        .idx (hw_idx)
    );

    // *****************************************
    // sequencer state
    // *****************************************
    cie_state_t  state, next_state;
    logic [15:0] sp, next_sp;
    logic [15:0] pc, next_pc;
    logic [15:0] vec_addr, next_vec_addr;
    logic        imask, next_imask;
    logic        dbg_pend, next_dbg_pend;
    logic        is_rti, next_is_rti;
    logic [7:0]  ccr_r, next_ccr_r;
    logic [7:0]  acc_r, next_acc_r;
    logic [7:0]  x_r, next_x_r;
    logic [7:0]  qb, next_qb;
    logic        qv, next_qv;
    logic        ent_d, next_ent_d;
    logic        rti_d, next_rti_d;
    logic [7:0]  ccr_stk;
    logic        take_trap;
    logic        take_hw;

    // trap instruction and debug trap share the vector and beat hardware
    assign take_trap = instr_boundary && !rti_exec && (swi_exec || dbg_pend);
    assign take_hw   = instr_boundary && !rti_exec && hw_any && !imask;

    // the stacked codes carry the mask as it stood before entry
    always_comb begin
        ccr_stk                 = ccr_in;
        ccr_stk[`CIE_CCR_I_BIT] = imask;
    end

    // next-state and memory access decode; upper index is never touched
    always_comb begin
        next_state    = state;
        next_sp       = sp;
        next_pc       = pc;
        next_vec_addr = vec_addr;
        next_imask    = imask;
        next_is_rti   = is_rti;
        next_ccr_r    = ccr_r;
        next_acc_r    = acc_r;
        next_x_r      = x_r;
        next_qb       = qb;
        next_qv       = 1'b0;
        next_ent_d    = 1'b0;
        next_rti_d    = 1'b0;
        next_dbg_pend = dbg_pend | dbg_swi;
        mem_rd        = 1'b0;
        mem_wr        = 1'b0;
        mem_addr      = sp;
        mem_wdata     = `CIE_BYTE_RST;
        case (state)
            CIE_ST_IDLE: begin
                // routine code may reopen the mask to nest
                if (ccr_i_clr) begin
                    next_imask = 1'b0;
                end
                if (ccr_i_set) begin
                    next_imask = 1'b1;
                end
                if (instr_boundary && rti_exec) begin
                    next_sp     = sp_in;
                    next_is_rti = 1'b1;
                    next_state  = CIE_ST_PULL_CCR;
                end else if (take_trap || take_hw) begin
                    next_sp     = sp_in;
                    next_pc     = pc_next;
                    next_is_rti = 1'b0;
                    next_state  = CIE_ST_PUSH_PCL;
                    if (take_trap) begin
                        next_vec_addr = `CIE_VEC_SWI;
                        if (!swi_exec) begin
                            next_dbg_pend = dbg_swi;
                        end
                    end else begin
                        next_vec_addr = 16'(`CIE_VEC_SRC0 - (16'(hw_idx) << 1));
                    end
                end
            end
            CIE_ST_PUSH_PCL: begin
                mem_wr     = 1'b1;
                mem_wdata  = pc[7:0];
                next_sp    = sp - 16'h0001;
                next_state = CIE_ST_PUSH_PCH;
            end
            CIE_ST_PUSH_PCH: begin
                mem_wr     = 1'b1;
                mem_wdata  = pc[15:8];
                next_sp    = sp - 16'h0001;
                next_state = CIE_ST_PUSH_X;
            end
            CIE_ST_PUSH_X: begin
                mem_wr     = 1'b1;
                mem_wdata  = idx_lo_in;
                next_sp    = sp - 16'h0001;
                next_state = CIE_ST_PUSH_A;
            end
            CIE_ST_PUSH_A: begin
                mem_wr     = 1'b1;
                mem_wdata  = acc_in;
                next_sp    = sp - 16'h0001;
                next_state = CIE_ST_PUSH_CCR;
            end
            CIE_ST_PUSH_CCR: begin
                mem_wr     = 1'b1;
                mem_wdata  = ccr_stk;
                next_sp    = sp - 16'h0001;
                next_imask = 1'b1;
                next_state = CIE_ST_VEC_HI;
            end
            CIE_ST_VEC_HI: begin
                mem_rd     = 1'b1;
                mem_addr   = vec_addr;
                next_state = CIE_ST_VEC_LO;
            end
            CIE_ST_VEC_LO: begin
                mem_rd          = 1'b1;
                mem_addr        = vec_addr + 16'h0001;
                next_pc[15:8]   = mem_rdata;
                next_state      = CIE_ST_VEC_END;
            end
            CIE_ST_VEC_END: begin
                next_pc[7:0] = mem_rdata;
                next_state   = CIE_ST_FILL0;
            end
            CIE_ST_PULL_CCR: begin
                mem_rd     = 1'b1;
                mem_addr   = sp + 16'h0001;
                next_sp    = sp + 16'h0001;
                next_state = CIE_ST_PULL_A;
            end
            CIE_ST_PULL_A: begin
                mem_rd     = 1'b1;
                mem_addr   = sp + 16'h0001;
                next_sp    = sp + 16'h0001;
                next_ccr_r = mem_rdata;
                next_imask = mem_rdata[`CIE_CCR_I_BIT];
                next_state = CIE_ST_PULL_X;
            end
            CIE_ST_PULL_X: begin
                mem_rd     = 1'b1;
                mem_addr   = sp + 16'h0001;
                next_sp    = sp + 16'h0001;
                next_acc_r = mem_rdata;
                next_state = CIE_ST_PULL_PCH;
            end
            CIE_ST_PULL_PCH: begin
                mem_rd     = 1'b1;
                mem_addr   = sp + 16'h0001;
                next_sp    = sp + 16'h0001;
                next_x_r   = mem_rdata;
                next_state = CIE_ST_PULL_PCL;
            end
            CIE_ST_PULL_PCL: begin
                mem_rd        = 1'b1;
                mem_addr      = sp + 16'h0001;
                next_sp       = sp + 16'h0001;
                next_pc[15:8] = mem_rdata;
                next_state    = CIE_ST_PULL_END;
            end
            CIE_ST_PULL_END: begin
                next_pc[7:0] = mem_rdata;
                next_state   = CIE_ST_FILL0;
            end
            CIE_ST_FILL0: begin
                mem_rd     = 1'b1;
                mem_addr   = pc;
                next_state = CIE_ST_FILL1;
            end
            CIE_ST_FILL1: begin
                mem_rd     = 1'b1;
                mem_addr   = pc + 16'h0001;
                next_qb    = mem_rdata;
                next_qv    = 1'b1;
                next_state = CIE_ST_FILL2;
            end
            CIE_ST_FILL2: begin
                mem_rd     = 1'b1;
                mem_addr   = pc + 16'h0002;
                next_qb    = mem_rdata;
                next_qv    = 1'b1;
                next_state = CIE_ST_FILL_END;
            end
            CIE_ST_FILL_END: begin
                // third queue byte lands with the done pulse
                next_qb    = mem_rdata;
                next_qv    = 1'b1;
                next_ent_d = !is_rti;
                next_rti_d = is_rti;
                next_state = CIE_ST_IDLE;
            end
            default: begin
                next_state = CIE_ST_IDLE;
            end
        endcase
    end

    // registers only; mask comes up set so no hardware request fires before setup
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state    <= CIE_ST_IDLE;
            sp       <= `CIE_WORD_RST;
            pc       <= `CIE_WORD_RST;
            vec_addr <= `CIE_WORD_RST;
            imask    <= `CIE_IMASK_RST;
            dbg_pend <= 1'b0;
            is_rti   <= 1'b0;
            ccr_r    <= `CIE_BYTE_RST;
            acc_r    <= `CIE_BYTE_RST;
            x_r      <= `CIE_BYTE_RST;
            qb       <= `CIE_BYTE_RST;
            qv       <= 1'b0;
            ent_d    <= 1'b0;
            rti_d    <= 1'b0;
        end else if (clk_en) begin
            state    <= next_state;
            sp       <= next_sp;
            pc       <= next_pc;
            vec_addr <= next_vec_addr;
            imask    <= next_imask;
            dbg_pend <= next_dbg_pend;
            is_rti   <= next_is_rti;
            ccr_r    <= next_ccr_r;
            acc_r    <= next_acc_r;
            x_r      <= next_x_r;
            qb       <= next_qb;
            qv       <= next_qv;
            ent_d    <= next_ent_d;
            rti_d    <= next_rti_d;
        end
    end

    // outputs straight from flops, busy decoded from state
    assign busy            = (state != CIE_ST_IDLE);
    assign i_mask          = imask;
    assign stack_pointer   = sp;
    assign program_counter = pc;
    assign ccr_out         = ccr_r;
    assign acc_out         = acc_r;
    assign idx_lo_out      = x_r;
    assign q_byte          = qb;
    assign q_valid         = qv;
    assign entry_done      = ent_d;
    assign rti_done        = rti_d;

    // *****************************************
    // checks
    // *****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !clk_en);

    property p_mask_rst;
        $past(sys_rst) |-> imask;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask clear after reset");

    property p_masked;
        (state == CIE_ST_IDLE) && !rti_exec && !swi_exec && !dbg_pend && imask |=> !mem_wr;
    endproperty
    a_masked: assert property (p_masked) else $error("masked request started entry");

    property p_boundary;
        (state == CIE_ST_IDLE) && !instr_boundary |=> (state == CIE_ST_IDLE);
    endproperty
    a_boundary: assert property (p_boundary) else $error("sequence started mid instruction");

    property p_first_push;
        (state == CIE_ST_IDLE) && (take_trap || take_hw)
        |=> mem_wr && (mem_addr == $past(sp_in)) && (mem_wdata == $past(pc_next[7:0]))
            ##1 mem_wr && (mem_wdata == $past(pc_next[15:8], 2));
    endproperty
    a_first_push: assert property (p_first_push) else $error("wrong first stacked bytes");

    property p_sp_after;
        (state == CIE_ST_PUSH_CCR) |=> (sp == $past(mem_addr) - 16'h0001) && imask;
    endproperty
    a_sp_after: assert property (p_sp_after) else $error("stack pointer wrong after stacking");

    property p_vec_pair;
        (state == CIE_ST_VEC_HI) |=> mem_rd && (mem_addr == $past(mem_addr) + 16'h0001);
    endproperty
    a_vec_pair: assert property (p_vec_pair) else $error("vector low byte address wrong");

    property p_fill;
        (state == CIE_ST_FILL0) |-> ##2 qv [*3] ##1 !qv;
    endproperty
    a_fill: assert property (p_fill) else $error("queue not filled with three bytes");

    property p_pull;
        (state == CIE_ST_PULL_CCR) |-> (mem_addr == sp + 16'h0001) ##1 (sp == $past(sp) + 16'h0001);
    endproperty
    a_pull: assert property (p_pull) else $error("pull address not pre-incremented");

    property p_prio;
        (state == CIE_ST_IDLE) && take_hw && !take_trap
        |=> (vec_addr == 16'(`CIE_VEC_SRC0 - (16'($past(hw_idx)) << 1)))
                    && (($past(hw_req) >> $past(hw_idx)) == N'(1));
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority source won");

    property p_dbg;
        dbg_swi |=> dbg_pend || busy;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug trap lost");

    c_entry: cover property (entry_done);
    c_rti: cover property (rti_done);
    c_dbg_taken: cover property (dbg_pend && take_trap && !swi_exec);
    c_nest: cover property (busy && !is_rti ##1 (state == CIE_ST_IDLE) ##[1:50] take_hw && (sp < sp_in));

endmodule
`default_nettype wire

// ---- logic/cie_defines.svh ----
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH


// *****************************************
// vector map
// *****************************************
`define CIE_VEC_SWI   16'hFFFC
`define CIE_VEC_SRC0  16'hFFFA

// *****************************************
// condition code layout and reset values
// *****************************************
`define CIE_CCR_I_BIT 3
`define CIE_IMASK_RST 1'b1
`define CIE_WORD_RST  16'h0000
`define CIE_BYTE_RST  8'h00

`endif

// ---- logic/cie_pkg.sv ----
`default_nettype none
package cie_pkg;

    // sequencer states, at most one memory access per state
    typedef enum logic [4:0] {
        CIE_ST_IDLE     = 5'b00000,
        CIE_ST_PUSH_PCL = 5'b00001,
        CIE_ST_PUSH_PCH = 5'b00010,
        CIE_ST_PUSH_X   = 5'b00011,
        CIE_ST_PUSH_A   = 5'b00100,
        CIE_ST_PUSH_CCR = 5'b00101,
        CIE_ST_VEC_HI   = 5'b00110,
        CIE_ST_VEC_LO   = 5'b00111,
        CIE_ST_VEC_END  = 5'b01000,
        CIE_ST_PULL_CCR = 5'b01001,
        CIE_ST_PULL_A   = 5'b01010,
        CIE_ST_PULL_X   = 5'b01011,
        CIE_ST_PULL_PCH = 5'b01100,
        CIE_ST_PULL_PCL = 5'b01101,
        CIE_ST_PULL_END = 5'b01110,
        CIE_ST_FILL0    = 5'b01111,
        CIE_ST_FILL1    = 5'b10000,
        CIE_ST_FILL2    = 5'b10001,
        CIE_ST_FILL_END = 5'b10010
    } cie_state_t;

endpackage
`default_nettype wire

// ---- logic/cie_flags.sv ----
`timescale 1ns/10ps
`default_nettype none
module cie_flags #(
    parameter int N = 8
) (
    input  wire logic         clk_sys,  // core bus clock
    input  wire logic         sys_rst,  // sync reset, high
    input  wire logic         clk_en,   // freeze when low
    input  wire logic [N-1:0] evt,      // source event pulses
    input  wire logic [N-1:0] clr,      // software flag clear
    output logic      [N-1:0] flag      // sticky status flags
);
    import cie_pkg::*;

    logic [N-1:0] next_flag;

    // set beats clear so an event in the clear cycle survives
    always_comb begin
        next_flag = (flag & ~clr) | evt;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag <= '0;
        end else if (clk_en) begin
            flag <= next_flag;
        end
    end

    // *****************************************
    // checks
    // *****************************************
    property p_flag_set;
        @(posedge clk_sys) disable iff (sys_rst || !clk_en)
        (evt != '0) |=> ((flag & $past(evt)) == $past(evt));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

    property p_flag_clr;
        @(posedge clk_sys) disable iff (sys_rst || !clk_en)
        (clr != '0) |=> ((flag & $past(clr) & ~$past(evt)) == '0);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("cleared flag stayed set");

endmodule
`default_nettype wire

// ---- logic/cie_prio.sv ----
`timescale 1ns/10ps
`default_nettype none
module cie_prio #(
    parameter int N     = 8,
    parameter int IDX_W = 3
) (
    input  wire logic [N-1:0]     req,  // qualified requests
    output logic                  any,  // at least one request
    output logic      [IDX_W-1:0] idx   // winning source
);
    import cie_pkg::*;

    // higher index means higher priority; last hit wins the scan
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// ---- verification/cie_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
// ***************************
// stack and program memory
// ***************************
module cie_mem (
    input  wire logic        clk_sys,   // core bus clock
    input  wire logic        mem_rd,    // read strobe
    input  wire logic        mem_wr,    // write strobe
    input  wire logic [15:0] mem_addr,  // access address
    input  wire logic [7:0]  mem_wdata, // write data
    output logic      [7:0]  mem_rdata  // data of last cycle's read
);
    logic [7:0] m [0:65535];

    // one-cycle read latency; idle cycles flip the bus so stale data never matches
    always @(posedge clk_sys) begin
        if (mem_wr === 1'b1) begin
            m[mem_addr] <= mem_wdata;
        end
        mem_rdata <= (mem_rd === 1'b1) ? m[mem_addr] : ~mem_rdata;
    end

    initial begin
        mem_rdata = 8'h00;
    end
endmodule
`default_nettype wire

// ---- verification/cie_seq_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module cie_seq_bench;
    import cie_pkg::*;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, dbg_swi = 1'b0;
    logic        instr_boundary = 1'b0, swi_exec = 1'b0, rti_exec = 1'b0;
    logic        ccr_i_set = 1'b0, ccr_i_clr = 1'b0;
    logic [7:0]  src_event = 8'h00, src_ien = 8'h05, src_flag_clr = 8'h00;
    logic [15:0] pc_next = 16'h8123, sp_in = 16'h00FF;
    logic [7:0]  acc_in = 8'h5A, idx_lo_in = 8'hC3, ccr_in = 8'h60;
    logic        mem_rd, mem_wr, busy, i_mask, q_valid, entry_done, rti_done;
    logic [15:0] mem_addr, stack_pointer, program_counter;
    logic [7:0]  mem_wdata, mem_rdata, ccr_out, acc_out, idx_lo_out, q_byte, src_flag;
    int          bad_count = 0;
    int          checks = 0;
    logic [7:0]  qq [$];

    cie_seq dut_u (.clk_sys, .sys_rst, .clk_en(1'b1), .src_event, .src_ien, .src_flag_clr,
        .src_flag, .instr_boundary, .swi_exec, .rti_exec, .dbg_swi, .ccr_i_set, .ccr_i_clr,
        .pc_next, .sp_in, .acc_in, .idx_lo_in, .ccr_in, .mem_rd, .mem_wr, .mem_addr,
        .mem_wdata, .mem_rdata, .busy, .i_mask, .stack_pointer, .program_counter, .ccr_out,
        .acc_out, .idx_lo_out, .q_byte, .q_valid, .entry_done, .rti_done);
    cie_mem mem_u (.clk_sys, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

    // clock and queue byte capture
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (q_valid === 1'b1) begin
            qq.push_back(q_byte);
        end
    end

    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // queue must hold exactly three bytes from base address a
    task automatic qchk(logic [15:0] a);
        chk("qlen", 16'(qq.size()), 16'h0003);
        for (int i = 0; i < 3; i++) begin
            chk("qbyte", {8'h00, qq[i]}, {8'h00, mem_u.m[a + 16'(i)]});
        end
        qq.delete();
    endtask

    // one boundary, then wait bounded for the done pulse when a run is expected
    task automatic bnd(logic s, logic r, logic run);
        int k;
        k = 0;
        @(negedge clk_sys);
        instr_boundary = 1'b1;
        swi_exec = s;
        rti_exec = r;
        @(negedge clk_sys);
        instr_boundary = 1'b0;
        swi_exec = 1'b0;
        rti_exec = 1'b0;
        chk("busy", {15'h0, busy}, {15'h0, run});
        while (run && entry_done !== 1'b1 && rti_done !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        // let the edge after the done pulse capture the third queue byte
        if (run) begin
            @(negedge clk_sys);
        end
        chk("done", 16'(k < 20), 16'h0001);
    endtask

    task automatic pulse(ref logic [7:0] v, input logic [7:0] b);
        @(negedge clk_sys);
        v = b;
        @(negedge clk_sys);
        v = 8'h00;
    endtask

    task automatic t_masked;
        chk("mask", {15'h0, i_mask}, 16'h0001);
        pulse(src_event, 8'h04);
        chk("flag", {8'h00, src_flag}, 16'h0004);
        bnd(1'b0, 1'b0, 1'b0);
    endtask

    // two pending sources, mask cleared, entry stacks and takes source 2
    task automatic t_entry;
        logic [7:0] fr [5];
        fr = '{8'h23, 8'h81, 8'hC3, 8'h5A, 8'h60};
        pulse(src_event, 8'h01);
        @(negedge clk_sys);
        ccr_i_clr = 1'b1;
        @(negedge clk_sys);
        ccr_i_clr = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("idle", {15'h0, busy}, 16'h0000);
        bnd(1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            chk("stack", {8'h00, mem_u.m[16'h00FF - 16'(i)]}, {8'h00, fr[i]});
        end
        chk("sp", stack_pointer, 16'h00FA);
        chk("vec", program_counter, 16'h1234);
        chk("mask", {15'h0, i_mask}, 16'h0001);
        qchk(16'h1234);
        pulse(src_flag_clr, 8'h04);
        @(negedge clk_sys);
        ccr_i_clr = 1'b1;
        @(negedge clk_sys);
        ccr_i_clr = 1'b0;
        chk("nest", {15'h0, i_mask}, 16'h0000);
        pulse(src_event, 8'h04);
        chk("again", {8'h00, src_flag}, 16'h0005);
    endtask

    task automatic t_return;
        sp_in = 16'h00FA;
        bnd(1'b0, 1'b1, 1'b1);
        chk("ccr", {8'h00, ccr_out}, 16'h0060);
        chk("acc", {8'h00, acc_out}, 16'h005A);
        chk("x", {8'h00, idx_lo_out}, 16'h00C3);
        chk("pc", program_counter, 16'h8123);
        chk("sp", stack_pointer, 16'h00FF);
        chk("mask", {15'h0, i_mask}, 16'h0000);
        qchk(16'h8123);
        sp_in = 16'h00FF;
    endtask

    // software trap taken with mask set and a masked source pending; debug trap runs with mask set
    task automatic t_traps;
        @(negedge clk_sys);
        ccr_i_set = 1'b1;
        @(negedge clk_sys);
        ccr_i_set = 1'b0;
        chk("set", {15'h0, i_mask}, 16'h0001);
        bnd(1'b1, 1'b0, 1'b1);
        chk("swi", program_counter, 16'h5678);
        qchk(16'h5678);
        @(negedge clk_sys);
        dbg_swi = 1'b1;
        @(negedge clk_sys);
        dbg_swi = 1'b0;
        bnd(1'b0, 1'b0, 1'b1);
        chk("dbg", program_counter, 16'h5678);
        qq.delete();
    endtask

    // flag cleared before the boundary leaves nothing to serve
    task automatic t_cleared;
        src_ien = 8'h01;
        @(negedge clk_sys);
        ccr_i_clr = 1'b1;
        @(negedge clk_sys);
        ccr_i_clr = 1'b0;
        pulse(src_event, 8'h01);
        src_flag_clr = 8'h01;
        @(negedge clk_sys);
        src_flag_clr = 8'h00;
        bnd(1'b0, 1'b0, 1'b0);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        mem_u.m[16'hFFF6] = 8'h12;
        mem_u.m[16'hFFF7] = 8'h34;
        mem_u.m[16'hFFFC] = 8'h56;
        mem_u.m[16'hFFFD] = 8'h78;
        for (int i = 0; i < 3; i++) begin
            mem_u.m[16'h1234 + 16'(i)] = 8'hA1 + 8'(i);
            mem_u.m[16'h8123 + 16'(i)] = 8'hB1 + 8'(i);
            mem_u.m[16'h5678 + 16'(i)] = 8'hD1 + 8'(i);
        end
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_masked();
        t_entry();
        t_return();
        t_traps();
        t_cleared();
        results();
    end

    // watchdog, run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
